// ==== src/eisc_pkg.sv ====
package eisc_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD  = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  // instruction codes written to the command register
  localparam logic [7:0] CMD_SKIP_IF_EXT_FLAG = 8'h01;
  localparam logic [7:0] CMD_POWERDOWN_ARM    = 8'h02;
  localparam logic [7:0] CMD_RAM_BACKUP       = 8'h03;
  localparam logic [7:0] CMD_IRQ_DISABLE      = 8'h04;
  localparam logic [7:0] CMD_IRQ_ENABLE       = 8'h05;
  localparam logic [7:0] CMD_SEL_CERAMIC      = 8'h06;
  localparam logic [7:0] CMD_SEL_RC           = 8'h07;
  // field positions inside pin_irq_control_reg
  localparam int PIN_IN_EN = 3;
  localparam int PIN_WAVE  = 2;
  localparam int PIN_BOTH  = 1;
  localparam int PIN_T1    = 0;
  // reset values and timing
  localparam logic [3:0] PIN_CTRL_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         STAB_TICKS   = 16;

  typedef enum logic [1:0] {
    OSC_ONCHIP  = 2'h0,
    OSC_CERAMIC = 2'h1,
    OSC_RC      = 2'h2
  } eisc_osc_t;

  // gray order: wait -> run -> backup
  typedef enum logic [1:0] {
    PWR_WAIT   = 2'h0,
    PWR_RUN    = 2'h1,
    PWR_BACKUP = 2'h3
  } eisc_pwr_t;

  typedef struct packed {
    logic [3:0] pin_irq_control_reg;
    logic [2:0] rsvd;
    logic       irq_enable_reg_one;
  } eisc_ctrl_t;

  typedef struct packed {
    logic      gie;
    logic      stable;
    eisc_osc_t osc;
    logic      backup;
    logic      armed;
    logic      skip;
    logic      ext_irq_request_flag;
  } eisc_stat_t;
endpackage : eisc_pkg

// ==== src/eisc_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - Changing the pin input-enable bit may set the request flag, depending on the pin level.
// - Changing the waveform bit may set the request flag, depending on the pin level.
// - With the interrupt disabled, the flag test clears the flag and skips when it was set.
// - Ram back-up is entered only by power-down right after the arming instruction.
// - Power-down without the arming instruction just before it does not enter back-up.
// - Ram back-up is unavailable while the clock source is an external clock.
// - Only the first oscillator selection takes effect; later ones are ignored.
// - The stabilise wait after reset is timed by the on-chip oscillator.
// - Enable bit zero makes the flag test effective; one makes it a no-operation.
// - Waveform bit zero picks falling edge and low level, one rising edge and high level.
// - A control bit picks one chosen edge or both edges of the pin.
// - The input-enable bit gates the pin into detection: zero blocks, one passes.
module eisc_top #(
  parameter int STAB = eisc_pkg::STAB_TICKS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        shared_port_bit,
  input  wire logic        osc_input_pin_ext_clk,
  input  wire logic        onchip_osc_clk,
  output logic             ext_irq,
  output logic             ram_backup,
  output logic [1:0]       osc_select,
  output logic             osc_stable
);
  // axi write/read state
  logic              aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [7:0]        awaddr_ff, nxt_awaddr;
  logic [31:0]       wdata_ff, nxt_wdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic              awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic              bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic              wr_go;
  // core state
  eisc_pkg::eisc_ctrl_t ctrl_ff, nxt_ctrl;
  eisc_pkg::eisc_osc_t  osc_ff, nxt_osc;
  eisc_pkg::eisc_pwr_t  pwr_ff, nxt_pwr;
  eisc_pkg::eisc_stat_t stat;
  logic              flag_ff, nxt_flag, skip_ff, nxt_skip, armed_ff, nxt_armed;
  logic              gie_ff, nxt_gie, sense_ff, nxt_sense, irq_ff, nxt_irq;
  logic              bkup_ff, stable_ff;
  logic [15:0]       cnt_ff, nxt_cnt;
  logic              pin_s1_ff, pin_s2_ff, ext_s1_ff, ext_s2_ff;
  logic              tick_s1_ff, tick_s2_ff, tick_s3_ff;
  logic              sense, edge_ev, tick_rise, cmd_fire;
  logic [7:0]        cmd;

  // two-stage synchronisers for pins and the on-chip oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pin_s1_ff, pin_s2_ff, ext_s1_ff, ext_s2_ff} <= 4'h0;
      {tick_s1_ff, tick_s2_ff, tick_s3_ff}         <= 3'h0;
    end else if (ce) begin
      pin_s1_ff  <= shared_port_bit;
      pin_s2_ff  <= pin_s1_ff;
      ext_s1_ff  <= osc_input_pin_ext_clk;
      ext_s2_ff  <= ext_s1_ff;
      tick_s1_ff <= onchip_osc_clk;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  // axi4-lite slave: address and data taken in either order, response after both
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    if (wr_go) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (awaddr_ff == eisc_pkg::ADDR_CTRL || awaddr_ff == eisc_pkg::ADDR_CMD)
                    ? eisc_pkg::RESP_OKAY : eisc_pkg::RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready  = !nxt_w_have && !nxt_bvalid;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = eisc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        eisc_pkg::ADDR_CTRL: nxt_rdata = {24'h0, ctrl_ff};
        eisc_pkg::ADDR_STAT: nxt_rdata = {24'h0, stat};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = (s_axi_araddr == eisc_pkg::ADDR_CMD) ? eisc_pkg::RESP_OKAY
                                                           : eisc_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 8'h0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= eisc_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= eisc_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else if (ce) begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // status word as software sees it
  always_comb begin
    stat.gie                  = gie_ff;
    stat.stable               = stable_ff;
    stat.osc                  = osc_ff;
    stat.backup               = bkup_ff;
    stat.armed                = armed_ff;
    stat.skip                 = skip_ff;
    stat.ext_irq_request_flag = flag_ff;
  end

  // edge detection, request flag, power-down sequencing, oscillator choice
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_flag  = flag_ff;
    nxt_skip  = skip_ff;
    nxt_armed = armed_ff;
    nxt_gie   = gie_ff;
    nxt_osc   = osc_ff;
    nxt_pwr   = pwr_ff;
    nxt_cnt   = cnt_ff;
    cmd       = wdata_ff[7:0];
    cmd_fire  = wr_go && awaddr_ff == eisc_pkg::ADDR_CMD && wstrb_ff[0];
    tick_rise = tick_s2_ff && !tick_s3_ff;
    // gated pin, inverted for falling mode so the active edge is a rise
    sense = ctrl_ff.pin_irq_control_reg[eisc_pkg::PIN_IN_EN] &&
            (pin_s2_ff ~^ ctrl_ff.pin_irq_control_reg[eisc_pkg::PIN_WAVE]);
    nxt_sense = sense;
    // gate or polarity changes move sense too and can fake an edge
    edge_ev = ctrl_ff.pin_irq_control_reg[eisc_pkg::PIN_BOTH] ? (sense ^ sense_ff)
                                                              : (sense && !sense_ff);
    if (wr_go && awaddr_ff == eisc_pkg::ADDR_CTRL && wstrb_ff[0]) begin
      nxt_ctrl      = wdata_ff[7:0];
      nxt_ctrl.rsvd = 3'h0;
    end
    if (cmd_fire) begin
      nxt_armed = (cmd == eisc_pkg::CMD_POWERDOWN_ARM); // any other instruction disarms
      case (cmd)
        eisc_pkg::CMD_SKIP_IF_EXT_FLAG: begin
          if (!ctrl_ff.irq_enable_reg_one) begin
            nxt_skip = flag_ff;
            nxt_flag = 1'b0;
          end else begin
            nxt_skip = 1'b0;
          end
        end
        eisc_pkg::CMD_RAM_BACKUP: begin
          if (armed_ff && !ext_s2_ff && pwr_ff == eisc_pkg::PWR_RUN) begin
            nxt_pwr = eisc_pkg::PWR_BACKUP;
          end
        end
        eisc_pkg::CMD_IRQ_DISABLE: nxt_gie = 1'b0;
        eisc_pkg::CMD_IRQ_ENABLE:  nxt_gie = 1'b1;
        eisc_pkg::CMD_SEL_CERAMIC: begin
          if (osc_ff == eisc_pkg::OSC_ONCHIP) nxt_osc = eisc_pkg::OSC_CERAMIC;
        end
        eisc_pkg::CMD_SEL_RC: begin
          if (osc_ff == eisc_pkg::OSC_ONCHIP) nxt_osc = eisc_pkg::OSC_RC;
        end
        default: nxt_skip = skip_ff;
      endcase
    end
    if (edge_ev) begin
      nxt_flag = 1'b1;
    end
    // stabilise wait counts on-chip oscillator edges
    case (pwr_ff)
      eisc_pkg::PWR_WAIT: begin
        if (tick_rise) begin
          nxt_cnt = cnt_ff + 16'h1;
          if (cnt_ff == 16'(STAB - 1)) begin
            nxt_pwr = eisc_pkg::PWR_RUN;
            nxt_cnt = 16'h0;
          end
        end
      end
      eisc_pkg::PWR_BACKUP: begin
        if (edge_ev) begin
          nxt_pwr = eisc_pkg::PWR_WAIT; // key-on wakeup restarts the wait
        end
      end
      default: nxt_cnt = cnt_ff;
    endcase
    nxt_irq = nxt_flag && nxt_ctrl.irq_enable_reg_one && nxt_gie;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff   <= '{pin_irq_control_reg: eisc_pkg::PIN_CTRL_RST, rsvd: 3'h0,
                     irq_enable_reg_one: 1'b0};
      flag_ff   <= 1'b0;
      skip_ff   <= 1'b0;
      armed_ff  <= 1'b0;
      gie_ff    <= 1'b0;
      sense_ff  <= 1'b0;
      osc_ff    <= eisc_pkg::OSC_ONCHIP;
      pwr_ff    <= eisc_pkg::PWR_WAIT;
      cnt_ff    <= 16'h0;
      irq_ff    <= 1'b0;
      bkup_ff   <= 1'b0;
      stable_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff   <= nxt_ctrl;
      flag_ff   <= nxt_flag;
      skip_ff   <= nxt_skip;
      armed_ff  <= nxt_armed;
      gie_ff    <= nxt_gie;
      sense_ff  <= nxt_sense;
      osc_ff    <= nxt_osc;
      pwr_ff    <= nxt_pwr;
      cnt_ff    <= nxt_cnt;
      irq_ff    <= nxt_irq;
      bkup_ff   <= (nxt_pwr == eisc_pkg::PWR_BACKUP);
      stable_ff <= (nxt_pwr != eisc_pkg::PWR_WAIT);
    end
  end

  assign ext_irq    = irq_ff;
  assign ram_backup = bkup_ff;
  assign osc_select = osc_ff;
  assign osc_stable = stable_ff;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flag_sets_a: assert property (ce && edge_ev |=> flag_ff)
    else $error("detected edge did not set the request flag");
  snz_clears_a: assert property (ce && cmd_fire && !edge_ev && !ctrl_ff.irq_enable_reg_one
    && cmd == eisc_pkg::CMD_SKIP_IF_EXT_FLAG |=> !flag_ff && skip_ff == $past(flag_ff))
    else $error("flag test did not clear flag or report skip");
  snz_nop_a: assert property (ce && cmd_fire && ctrl_ff.irq_enable_reg_one && flag_ff
    && cmd == eisc_pkg::CMD_SKIP_IF_EXT_FLAG |=> flag_ff && !skip_ff)
    else $error("flag test acted while interrupt enabled");
  gate_blocks_a: assert property (ce && !sense_ff && !flag_ff
    && !ctrl_ff.pin_irq_control_reg[eisc_pkg::PIN_IN_EN] |=> !flag_ff)
    else $error("disabled pin set the request flag");
  backup_enter_a: assert property (ce && cmd_fire && armed_ff && !ext_s2_ff
    && pwr_ff == eisc_pkg::PWR_RUN && cmd == eisc_pkg::CMD_RAM_BACKUP |=> ram_backup)
    else $error("armed power-down did not enter back-up");
  backup_unarmed_a: assert property ($rose(pwr_ff == eisc_pkg::PWR_BACKUP)
    |-> $past(armed_ff))
    else $error("back-up entered without arming");
  backup_extclk_a: assert property ($rose(pwr_ff == eisc_pkg::PWR_BACKUP)
    |-> !$past(ext_s2_ff))
    else $error("back-up entered on external clock");
  osc_once_a: assert property (osc_ff != eisc_pkg::OSC_ONCHIP |=> $stable(osc_ff))
    else $error("oscillator choice changed twice");
  stab_tick_a: assert property (pwr_ff == eisc_pkg::PWR_WAIT && !tick_rise
    |=> $stable(cnt_ff) && pwr_ff == eisc_pkg::PWR_WAIT)
    else $error("stabilise wait advanced without an on-chip edge");

  flag_seen_c: cover property (ce && edge_ev ##1 flag_ff);
  backup_seen_c: cover property ($rose(ram_backup));
  osc_seen_c: cover property (osc_ff == eisc_pkg::OSC_RC);
endmodule : eisc_top

// ==== tb/eisc_far_end.sv ====
`timescale 1ns/1ps
// far side: interrupt pin source, external clock strap and on-chip oscillator
module eisc_far_end (
  input  wire logic       pin_lvl,
  input  wire logic       ext_lvl,
  input  wire logic [1:0] osc_select,
  output logic            shared_port_bit,
  output logic            osc_input_pin_ext_clk,
  output logic            onchip_osc_clk
);
  // pin and strap reach the device a little after the bench moves them
  assign #3 shared_port_bit = pin_lvl;
  assign #3 osc_input_pin_ext_clk = ext_lvl;
  // on-chip oscillator, unrelated to aclk; stops once a main oscillator wins
  initial begin
    onchip_osc_clk = 1'b0;
    forever begin
      #73;
      if (osc_select === 2'h0) begin
        onchip_osc_clk = ~onchip_osc_clk;
      end else begin
        onchip_osc_clk = 1'b0;
      end
    end
  end
endmodule : eisc_far_end

// ==== tb/ext_interrupt_standby_control_tb.sv ====
`timescale 1ns/1ps
module ext_interrupt_standby_control_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pin_lvl, ext_lvl, sp, xc, oc;
  logic        ext_irq, ram_backup, osc_stable, ce;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, osc_select;
  logic [3:0]  wstrb;
  int          failures, n_tests;
  eisc_top #(.STAB(2)) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shared_port_bit(sp), .osc_input_pin_ext_clk(xc), .onchip_osc_clk(oc),
    .ext_irq(ext_irq), .ram_backup(ram_backup), .osc_select(osc_select),
    .osc_stable(osc_stable));
  eisc_far_end far_u (.pin_lvl(pin_lvl), .ext_lvl(ext_lvl), .osc_select(osc_select),
    .shared_port_bit(sp), .osc_input_pin_ext_clk(xc), .onchip_osc_clk(oc));
  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // verdict and end of run
  task automatic conclude();
    $display("summary: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tmo(input string what);
    failures++;
    $display("MISMATCH at %0t: timeout in %s", $time, what);
    conclude();
  endtask : tmo
  // write: offer address and data together, drop each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = eisc_pkg::RESP_OKAY);
    logic aw, w, b;
    logic [1:0] r;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er}, "bresp");
        @(posedge aclk);
        return;
      end
    end
    tmo("write");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er = eisc_pkg::RESP_OKAY);
    logic ah, rh;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        chk({30'h0, r}, {30'h0, er}, "rresp");
        @(posedge aclk);
        return;
      end
    end
    tmo("read");
  endtask : rd
  task automatic cmd(input logic [7:0] c);
    wr(eisc_pkg::ADDR_CMD, {24'h0, c});
  endtask : cmd
  // plain instructions ahead of and after the flag test
  task automatic flag_test();
    cmd(8'h00);
    cmd(eisc_pkg::CMD_SKIP_IF_EXT_FLAG);
    cmd(8'h00);
  endtask : flag_test
  task automatic wait_lvl(input logic stab, input logic v);
    for (int i = 0; i < 800; i++) begin
      @(negedge aclk);
      if ((stab ? osc_stable : ram_backup) === v) return;
    end
    tmo("level wait");
  endtask : wait_lvl
  // reset values, register map, unmapped address, stabilise wait
  task automatic t_reset();
    @(negedge aclk);
    chk({27'h0, ext_irq, ram_backup, osc_stable, osc_select}, 32'h0, "reset outputs");
    wait_lvl(1'b1, 1'b1);
    @(posedge aclk);
    rd(eisc_pkg::ADDR_CTRL);
    chk(d, 32'h0, "ctrl reset");
    wr(eisc_pkg::ADDR_CTRL, 32'hff);
    rd(eisc_pkg::ADDR_CTRL);
    chk(d, 32'hf1, "ctrl bits");
    wr(eisc_pkg::ADDR_CTRL, 32'h0);
    wstrb <= 4'h0;
    wr(eisc_pkg::ADDR_CTRL, 32'hff);
    rd(eisc_pkg::ADDR_CTRL);
    chk(d, 32'h0, "masked write");
    wstrb <= 4'h1;
    wr(8'h0c, 32'h1, eisc_pkg::RESP_SLVERR);
    rd(8'h0c, eisc_pkg::RESP_SLVERR);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  // edge choice, gating and flag test, one case per row
  task automatic t_edges();
    logic [31:0] cc[5] = '{32'h80, 32'h80, 32'hc0, 32'he0, 32'h00};
    logic pe[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic ex[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 5; k++) begin
      pin_lvl <= ~pe[k];
      wr(eisc_pkg::ADDR_CTRL, cc[k]);
      repeat (4) @(posedge aclk);
      flag_test();
      pin_lvl <= pe[k];
      repeat (6) @(posedge aclk);
      rd(eisc_pkg::ADDR_STAT);
      chk(d & 32'h1, {31'h0, ex[k]}, "flag after edge");
      flag_test();
      rd(eisc_pkg::ADDR_STAT);
      chk(d & 32'h3, {30'h0, ex[k], 1'b0}, "flag test");
    end
    $display("test edges done");
  endtask : t_edges
  // control bit changes raise the flag; enabled flag test does nothing
  task automatic t_spurious();
    pin_lvl <= 1'b0;
    wr(eisc_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    flag_test();
    wr(eisc_pkg::ADDR_CTRL, 32'h80);
    repeat (5) @(posedge aclk);
    rd(eisc_pkg::ADDR_STAT);
    chk(d & 32'h1, 32'h1, "input enable change");
    pin_lvl <= 1'b1;
    repeat (4) @(posedge aclk);
    flag_test();
    wr(eisc_pkg::ADDR_CTRL, 32'hc0);
    repeat (5) @(posedge aclk);
    rd(eisc_pkg::ADDR_STAT);
    chk(d & 32'h1, 32'h1, "waveform change");
    wr(eisc_pkg::ADDR_CTRL, 32'hc1);
    cmd(eisc_pkg::CMD_IRQ_ENABLE);
    cmd(eisc_pkg::CMD_SKIP_IF_EXT_FLAG);
    rd(eisc_pkg::ADDR_STAT);
    chk({d[1:0], ext_irq}, 32'h3, "enabled flag test");
    cmd(eisc_pkg::CMD_IRQ_DISABLE);
    repeat (2) @(posedge aclk);
    chk({31'h0, ext_irq}, 32'h0, "disabled irq");
    wr(eisc_pkg::ADDR_CTRL, 32'hc0);
    flag_test();
    $display("test spurious done");
  endtask : t_spurious
  // back-up entry only by arm then power-down, never on external clock
  task automatic t_backup();
    cmd(eisc_pkg::CMD_RAM_BACKUP);
    rd(eisc_pkg::ADDR_STAT);
    chk({d[3], ram_backup}, 32'h0, "lone power-down");
    ext_lvl <= 1'b1;
    repeat (4) @(posedge aclk);
    cmd(eisc_pkg::CMD_POWERDOWN_ARM);
    cmd(eisc_pkg::CMD_RAM_BACKUP);
    chk({31'h0, ram_backup}, 32'h0, "external clock");
    ext_lvl <= 1'b0;
    repeat (4) @(posedge aclk);
    cmd(eisc_pkg::CMD_POWERDOWN_ARM);
    cmd(8'h00);
    cmd(eisc_pkg::CMD_RAM_BACKUP);
    chk({31'h0, ram_backup}, 32'h0, "arm broken");
    cmd(eisc_pkg::CMD_POWERDOWN_ARM);
    rd(eisc_pkg::ADDR_STAT);
    chk(d & 32'h4, 32'h4, "armed");
    cmd(eisc_pkg::CMD_RAM_BACKUP);
    chk({31'h0, ram_backup}, 32'h1, "back-up entry");
    pin_lvl <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b0;
    pin_lvl <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, ram_backup}, 32'h1, "no wake on fall or while frozen");
    ce <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    chk({31'h0, osc_stable}, 32'h0, "wait restarts");
    wait_lvl(1'b1, 1'b1);
    @(posedge aclk);
    $display("test backup done");
  endtask : t_backup
  // first oscillator choice wins
  task automatic t_osc();
    wr(eisc_pkg::ADDR_CTRL, 32'h0);
    cmd(eisc_pkg::CMD_SEL_CERAMIC);
    cmd(eisc_pkg::CMD_SEL_RC);
    repeat (2) @(posedge aclk);
    chk({30'h0, osc_select}, {30'h0, eisc_pkg::OSC_CERAMIC}, "osc choice");
    $display("test osc done");
  endtask : t_osc
  // main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pin_lvl, ext_lvl} = 8'h02;
    ce = 1'b1;
    wstrb = 4'h1;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_edges();
    t_spurious();
    t_backup();
    t_osc();
    conclude();
  end
endmodule : ext_interrupt_standby_control_tb
